//--- logic/drive_cmd_pkg.sv
// Shared constants for the drive command word decoder.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package drive_cmd_pkg;
    localparam int WORD_W = 16;
    localparam int TEL_W = 10;
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    // Command word bit positions
    localparam int B_ON = 0;
    localparam int B_NO_COAST = 1;
    localparam int B_NO_QUICK = 2;
    localparam int B_ENABLE_OP = 3;
    localparam int B_RAMP_KEEP = 4;
    localparam int B_RAMP_RUN = 5;
    localparam int B_SETP_EN = 6;
    localparam int B_ACK = 7;
    localparam int B_MASTER = 10;
    localparam int B_NO_INVERT = 11;
    localparam int B_POT_UP = 13;
    localparam int B_POT_DOWN = 14;
    localparam int B_CDS0 = 15;
    // State word bit positions
    localparam int S_READY_START = 0;
    localparam int S_READY = 1;
    localparam int S_OPER = 2;
    localparam int S_FAULT = 3;
    localparam int S_NO_COAST = 4;
    localparam int S_NO_QUICK = 5;
    localparam int S_LOCKOUT = 6;
    localparam int S_MASTER_REQ = 9;
    localparam int S_CDS = 15;
    // Register byte addresses
    localparam logic [ADR_W-1:0] ADDR_CMD = 8'h00;
    localparam logic [ADR_W-1:0] ADDR_SETP = 8'h04;
    localparam logic [ADR_W-1:0] ADDR_TEL = 8'h08;
    localparam logic [ADR_W-1:0] ADDR_STATE = 8'h0C;
    localparam logic [ADR_W-1:0] ADDR_SPEED = 8'h10;
    // Telegram numbers
    localparam logic [TEL_W-1:0] TEL_NAMUR = 10'h014;
    localparam logic [TEL_W-1:0] TEL_FREE = 10'h3E7;
    localparam logic [TEL_W-1:0] TEL_RESET = 10'h001;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
    localparam logic [WORD_W-1:0] POT_MAX = 16'h7FFF;
    localparam logic [WORD_W-1:0] POT_MIN = 16'h8001;
    typedef enum logic [2:0] {
        ST_LOCKOUT = 3'b000,
        ST_READY_START = 3'b001,
        ST_READY = 3'b010,
        ST_RUN = 3'b011,
        ST_RAMP_STOP = 3'b100,
        ST_QUICK_STOP = 3'b101,
        ST_FAULT = 3'b110
    } drive_state_t;
endpackage

//--- logic/pot_if.sv
// Link between the decoder and the setpoint potentiometer.
// Both ends run on the same clock.
`timescale 1ns/100ps
interface pot_if;
    import drive_cmd_pkg::*;
    logic up;
    logic down;
    logic signed [WORD_W-1:0] value;
    modport ctrl(output up, output down, input value);
    modport pot(input up, input down, output value);
endinterface

//--- logic/setpoint_potentiometer.sv
// Up/down setpoint store stepped at a prescaled rate.
// Assumes up and down come from logic on the same clock.
`timescale 1ns/100ps
module setpoint_potentiometer
    import drive_cmd_pkg::*;
#(
    parameter int PRESCALE = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    pot_if.pot pot
);
    logic [15:0] div_r;
    logic signed [WORD_W-1:0] value_r;
    wire tick = (div_r == 16'(PRESCALE - 1));
    wire go_up = pot.up & ~pot.down & (value_r != $signed(POT_MAX));
    wire go_down = pot.down & ~pot.up & (value_r != $signed(POT_MIN));

    assign pot.value = value_r;

    always_ff @(posedge clk_i) begin
        if (rst_i | tick) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    // Both bits high cancel each other rather than favouring one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            value_r <= $signed(WORD_ZERO);
        end else if (tick & go_up) begin
            value_r <= value_r + 16'sh0001;
        end else if (tick & go_down) begin
            value_r <= value_r - 16'sh0001;
        end
    end

    a_pot_up_step: assert property (@(posedge clk_i) disable iff (rst_i)
        tick & go_up |=> value_r == $past(value_r) + 16'sh0001)
        else $error("potentiometer did not step up");
    a_pot_down_step: assert property (@(posedge clk_i) disable iff (rst_i)
        tick & go_down |=> value_r == $past(value_r) - 16'sh0001)
        else $error("potentiometer did not step down");
endmodule

//--- logic/drive_control_word_decoder.sv
// Drive command word decoder with switch-on sequencing and ramp generator.
// Assumes a classic Wishbone master; fault_i comes from logic on clk_i.
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
// Contract
// - Bit 0 low ramps down normally and switches off at standstill.
// - Bit 0 rising enters ready; with bit 3 high the motor runs.
// - Bit 1 low switches off at once, motor coasts.
// - Bit 2 low brakes to standstill with the quick-stop ramp.
// - Bit 3 low cancels pulses at once; the code ignores it during quick stop and keeps pulses until standstill.
// - Bit 4 low forces ramp generator output to zero.
// - Bit 5 low freezes ramp generator output.
// - Bit 6 low ramps down; high ramps up to setpoint.
// - Bit 7 rising acknowledges faults; with bit 0 high enter closing lockout.
// - Bit 10 low makes the device ignore cyclic process data.
// - Outside telegram 20, bit 11 low inverts the setpoint.
// - Outside telegram 20, bit 13 high raises the potentiometer value.
// - Outside telegram 20, bit 14 high lowers the potentiometer value.
// - Switching into telegram 20 keeps earlier meaning of bits 11, 13, 14.
// - All telegrams except 999 move process data word by word.
// - Closing lockout holds until bit 0 goes low then high again.
module drive_control_word_decoder
    import drive_cmd_pkg::*;
#(
    parameter logic [WORD_W-1:0] UP_STEP = 16'h0001,
    parameter logic [WORD_W-1:0] DOWN_STEP = 16'h0001,
    parameter logic [WORD_W-1:0] QUICK_STEP = 16'h0004,
    parameter int POT_PRESCALE = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [SEL_W-1:0] wb_sel_i,
    input wire logic [DAT_W-1:0] wb_dat_i,
    output logic [DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic fault_i,
    output logic pulse_enable_o,
    output logic coast_stop_o,
    output logic quick_stop_o,
    output logic ramp_stop_o,
    output logic fault_ack_o,
    output logic cds_select_o,
    output logic signed [WORD_W-1:0] speed_ref_o
);
    // Byte-lane merge for the 16-bit registers
    function automatic logic [WORD_W-1:0] merge16(
        input logic [WORD_W-1:0] old_v,
        input logic [DAT_W-1:0] new_v,
        input logic [SEL_W-1:0] sel
    );
        logic [WORD_W-1:0] m;
        m = old_v;
        if (sel[0]) begin
            m[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            m[15:8] = new_v[15:8];
        end
        return m;
    endfunction

    // One ramp step toward the target, landing exactly on it
    function automatic logic signed [WORD_W-1:0] step_toward(
        input logic signed [WORD_W-1:0] cur,
        input logic signed [WORD_W-1:0] tgt,
        input logic [WORD_W-1:0] step
    );
        logic signed [WORD_W:0] d;
        logic signed [WORD_W:0] s;
        d = 17'(tgt) - 17'(cur);
        s = $signed({1'b0, step});
        if (d > s) begin
            return 16'(17'(cur) + s);
        end else if (d < -s) begin
            return 16'(17'(cur) - s);
        end
        return tgt;
    endfunction

    logic ack_r;
    logic [DAT_W-1:0] dat_r;
    logic [WORD_W-1:0] cmd_r;
    logic [WORD_W-1:0] prev_r;
    logic master_r;
    logic [TEL_W-1:0] tel_r;
    logic map_kept_r;
    logic signed [WORD_W-1:0] setp_r;
    logic signed [WORD_W-1:0] ramp_r;
    logic signed [WORD_W-1:0] ramp_nxt;
    logic fault_ack_r;
    drive_state_t state_r;
    drive_state_t state_nxt;

    pot_if pot_link();

    setpoint_potentiometer #(
        .PRESCALE(POT_PRESCALE)
    ) u_pot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pot(pot_link.pot)
    );

    // Bus decode; a write lands on the edge where ack is seen high
    wire req = wb_cyc_i & wb_stb_i;
    wire wr_en = req & wb_we_i & ack_r;
    wire wr_cmd = wr_en & (wb_adr_i == ADDR_CMD);
    wire wr_setp = wr_en & (wb_adr_i == ADDR_SETP);
    wire wr_tel = wr_en & (wb_adr_i == ADDR_TEL);
    wire [WORD_W-1:0] cmd_merged = merge16(cmd_r, wb_dat_i, wb_sel_i);
    wire [WORD_W-1:0] setp_merged = merge16(setp_r, wb_dat_i, wb_sel_i);
    wire tel_wr_full = wb_sel_i[0] & wb_sel_i[1];

    // Command word fields
    wire on_cmd = cmd_r[B_ON];
    wire no_coast = cmd_r[B_NO_COAST];
    wire no_quick = cmd_r[B_NO_QUICK];
    wire enable_op = cmd_r[B_ENABLE_OP];
    wire on_rise = cmd_r[B_ON] & ~prev_r[B_ON];
    wire ack_rise = cmd_r[B_ACK] & ~prev_r[B_ACK];
    wire is_namur = (tel_r == TEL_NAMUR);
    wire is_free = (tel_r == TEL_FREE);
    wire invert = map_kept_r & ~cmd_r[B_NO_INVERT];
    wire signed [WORD_W-1:0] setp_eff = invert ? -setp_r : setp_r;

    // State decode
    wire st_run = (state_r == ST_RUN);
    wire pulses = st_run | (state_r == ST_RAMP_STOP) | (state_r == ST_QUICK_STOP);
    wire at_rest = (ramp_r == $signed(WORD_ZERO));
    wire ramp_clear = ~pulses | (st_run & ~cmd_r[B_RAMP_KEEP]);
    wire ramp_freeze = st_run & ~cmd_r[B_RAMP_RUN];
    wire track = st_run & cmd_r[B_SETP_EN];
    wire signed [WORD_W-1:0] ramp_tgt = track ? setp_eff : $signed(WORD_ZERO);
    wire toward_zero = (ramp_tgt == $signed(WORD_ZERO)) | (ramp_r[WORD_W-1] != ramp_tgt[WORD_W-1]);
    wire [WORD_W-1:0] ramp_step = (state_r == ST_QUICK_STOP) ? QUICK_STEP :
        (toward_zero ? DOWN_STEP : UP_STEP);

    wire [WORD_W-1:0] state_word = {
        is_namur & cmd_r[B_CDS0],
        5'h00,
        master_r,
        2'h0,
        state_r == ST_LOCKOUT,
        no_quick,
        no_coast,
        state_r == ST_FAULT,
        pulses,
        st_run | (state_r == ST_READY),
        state_r != ST_FAULT
    };

    // Read mux; unmapped addresses read zero
    wire [DAT_W-1:0] rd_mux =
        (wb_adr_i == ADDR_CMD) ? {16'h0000, cmd_r} :
        (wb_adr_i == ADDR_SETP) ? {16'h0000, setp_r} :
        (wb_adr_i == ADDR_TEL) ? {22'h00_0000, tel_r} :
        (wb_adr_i == ADDR_STATE) ? {16'h0000, state_word} :
        (wb_adr_i == ADDR_SPEED) ? {pot_link.value, ramp_r} : 32'h0000_0000;

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign pulse_enable_o = pulses;
    assign coast_stop_o = ~no_coast;
    assign quick_stop_o = state_r == ST_QUICK_STOP;
    assign ramp_stop_o = state_r == ST_RAMP_STOP;
    assign fault_ack_o = fault_ack_r;
    assign cds_select_o = is_namur & cmd_r[B_CDS0];
    assign speed_ref_o = ramp_r;
    assign pot_link.up = map_kept_r & cmd_r[B_POT_UP];
    assign pot_link.down = map_kept_r & cmd_r[B_POT_DOWN];

    // Sequencing; fault first, then the fault state with its acknowledge, then coast stop over all other commands
    always_comb begin
        state_nxt = state_r;
        if (fault_i) begin
            state_nxt = ST_FAULT;
        end else if (state_r == ST_FAULT) begin
            if (ack_rise) begin
                state_nxt = on_cmd ? ST_LOCKOUT : ST_READY_START;
            end
        end else if (~no_coast) begin
            state_nxt = ST_LOCKOUT;
        end else begin
            unique case (state_r)
                ST_LOCKOUT: begin
                    if (~on_cmd & no_quick) begin
                        state_nxt = ST_READY_START;
                    end
                end
                ST_READY_START: begin
                    if (on_rise & no_quick) begin
                        state_nxt = enable_op ? ST_RUN : ST_READY;
                    end
                end
                ST_READY: begin
                    if (~no_quick) begin
                        state_nxt = ST_LOCKOUT;
                    end else if (~on_cmd) begin
                        state_nxt = ST_READY_START;
                    end else if (enable_op) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (~no_quick) begin
                        state_nxt = ST_QUICK_STOP;
                    end else if (~on_cmd) begin
                        state_nxt = ST_RAMP_STOP;
                    end else if (~enable_op) begin
                        state_nxt = ST_READY;
                    end
                end
                ST_RAMP_STOP: begin
                    if (~no_quick) begin
                        state_nxt = ST_QUICK_STOP;
                    end else if (~enable_op | at_rest) begin
                        state_nxt = ST_READY_START;
                    end
                end
                ST_QUICK_STOP: begin
                    if (at_rest) begin
                        state_nxt = ST_LOCKOUT;
                    end
                end
                default: begin
                    state_nxt = ST_LOCKOUT;
                end
            endcase
        end
    end

    // Ramp generator
    always_comb begin
        if (ramp_clear) begin
            ramp_nxt = $signed(WORD_ZERO);
        end else if (ramp_freeze) begin
            ramp_nxt = ramp_r;
        end else begin
            ramp_nxt = step_toward(ramp_r, ramp_tgt, ramp_step);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req & ~ack_r;
            dat_r <= (req & ~ack_r & ~wb_we_i) ? rd_mux : 32'h0000_0000;
        end
    end

    // Process data is only taken while the master bit of the new word is set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_r <= WORD_ZERO;
            master_r <= 1'b0;
        end else if (wr_cmd) begin
            master_r <= cmd_merged[B_MASTER];
            if (cmd_merged[B_MASTER]) begin
                cmd_r <= cmd_merged;
            end
        end
    end

    // Free interconnection has no word routing, so the setpoint word is held
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            setp_r <= $signed(WORD_ZERO);
        end else if (wr_setp & master_r & ~is_free) begin
            setp_r <= $signed(setp_merged);
        end
    end

    // Bits 11, 13, 14 lose meaning only if telegram 20 has always been in use
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tel_r <= TEL_RESET;
            map_kept_r <= (TEL_RESET != TEL_NAMUR);
        end else if (wr_tel & tel_wr_full) begin
            tel_r <= wb_dat_i[TEL_W-1:0];
            if (wb_dat_i[TEL_W-1:0] != TEL_NAMUR) begin
                map_kept_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_LOCKOUT;
            ramp_r <= $signed(WORD_ZERO);
            prev_r <= WORD_ZERO;
            fault_ack_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ramp_r <= ramp_nxt;
            prev_r <= cmd_r;
            fault_ack_r <= ack_rise;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_fault_cleared;
        state_r == ST_FAULT && ack_rise && !fault_i;
    endsequence
    sequence s_run_request;
        state_r == ST_READY_START && on_rise && no_coast && no_quick && enable_op && !fault_i;
    endsequence

    a_ramp_stop_entry: assert property (
        st_run && !on_cmd && no_coast && no_quick && !fault_i |=> state_r == ST_RAMP_STOP)
        else $error("bit 0 low did not start ramp stop");
    a_on_edge_run: assert property (s_run_request |=> st_run ##0 pulse_enable_o)
        else $error("rising on with enable did not run");
    a_coast_pulses: assert property (
        !no_coast && !fault_i && state_r != ST_FAULT |-> coast_stop_o ##1 (!pulse_enable_o && state_r == ST_LOCKOUT))
        else $error("coast stop kept pulses");
    a_quick_brake: assert property (
        state_r == ST_QUICK_STOP && !fault_i && no_coast |=> state_r inside {ST_QUICK_STOP, ST_LOCKOUT})
        else $error("quick stop left early");
    a_inhibit_pulses: assert property (
        st_run && on_cmd && no_coast && no_quick && !enable_op && !fault_i |=> state_r == ST_READY)
        else $error("inhibit did not cancel pulses");
    a_ramp_zero: assert property (
        st_run && !cmd_r[B_RAMP_KEEP] |=> ramp_r == $signed(WORD_ZERO))
        else $error("ramp not forced to zero");
    a_ramp_hold: assert property (
        st_run && cmd_r[B_RAMP_KEEP] && !cmd_r[B_RAMP_RUN] |=> ramp_r == $past(ramp_r))
        else $error("ramp not frozen");
    a_fault_lockout: assert property (
        s_fault_cleared ##0 on_cmd |=> state_r == ST_LOCKOUT && fault_ack_o)
        else $error("fault ack with on did not lock out");
    a_master_ignore: assert property (
        wr_cmd && !cmd_merged[B_MASTER] |=> cmd_r == $past(cmd_r))
        else $error("process data taken without master");
    a_lockout_hold: assert property (
        state_r == ST_LOCKOUT && on_cmd |=> state_r inside {ST_LOCKOUT, ST_FAULT})
        else $error("lockout left without off");
    a_cds_namur: assert property (!is_namur |-> !cds_select_o)
        else $error("data set select outside telegram 20");
endmodule

//--- dv/fieldbus_master_model.sv
// Fieldbus controller model: a classic Wishbone master posting words.
// Assumes one caller at a time and the decoder on the same clock.
`timescale 1ns/100ps
module fieldbus_master_model
    import drive_cmd_pkg::*;
(
    input wire logic clk_i,
    input wire logic wb_ack_i,
    input wire logic [DAT_W-1:0] wb_dat_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [ADR_W-1:0] wb_adr_o,
    output logic [SEL_W-1:0] wb_sel_o,
    output logic [DAT_W-1:0] wb_dat_o
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0000_0000;
    end

    // Entry edge leaves one idle cycle between requests
    task automatic req(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d,
                       output logic [DAT_W-1:0] q);
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= w;
        wb_adr_o <= a;
        wb_sel_o <= 4'hf;
        wb_dat_o <= d;
        do @(posedge clk_i); while (wb_ack_i !== 1'b1);
        q = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        // Released lines flip so stale values never look valid
        wb_adr_o <= ~a;
        wb_sel_o <= 4'h0;
        wb_dat_o <= ~d;
    endtask
endmodule

//--- dv/drive_control_word_decoder_tb.sv
// Bench for the command word decoder, bus traffic through the controller model.
// Assumes the decoder answers every bus request; reads are checked by a monitor.
`timescale 1ns/100ps
module drive_control_word_decoder_tb;
    import drive_cmd_pkg::*;
    localparam logic [WORD_W-1:0] RUN_W = 16'h0c7f;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic fault_i = 1'b0;
    logic cyc, stb, we, ack;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] wdat, rdat, rd_v, e_v, m_v;
    logic pen, coast, quick, rstop, fack, command_data_set_select;
    logic signed [WORD_W-1:0] spd, pot_v;
    logic [WORD_W-1:0] sp, nsp;
    logic [DAT_W-1:0] exp_q[$];
    logic [DAT_W-1:0] msk_q[$];
    int err_total = 0;
    int num_checks = 0;

    always #25 clk_i = ~clk_i;

    drive_control_word_decoder #(.POT_PRESCALE(2)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .fault_i(fault_i),
        .pulse_enable_o(pen), .coast_stop_o(coast), .quick_stop_o(quick),
        .ramp_stop_o(rstop), .fault_ack_o(fack), .cds_select_o(command_data_set_select), .speed_ref_o(spd));

    fieldbus_master_model ctl_u (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat),
        .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
        .wb_dat_o(wdat));

    task automatic cmp(input logic [DAT_W-1:0] got, input logic [DAT_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Oldest expected read is taken off the queue on each read answer
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            e_v = exp_q.pop_front();
            m_v = msk_q.pop_front();
            cmp(rdat & m_v, e_v & m_v);
        end
    end

    task automatic wr(input logic [ADR_W-1:0] a, input logic [WORD_W-1:0] d);
        logic [DAT_W-1:0] q;
        ctl_u.req(1'b1, a, {16'h0000, d}, q);
    endtask

    task automatic rd(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e, input logic [DAT_W-1:0] m);
        logic [DAT_W-1:0] q;
        exp_q.push_back(e);
        msk_q.push_back(m);
        ctl_u.req(1'b0, a, 32'h0000_0000, q);
        rd_v = q;
    endtask

    task automatic st(input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] m);
        rd(ADDR_STATE, {16'h0000, e}, {16'h0000, m});
    endtask

    // The ramp is settled whenever this is called, so the speed output must match the read
    task automatic spd_is(input logic [WORD_W-1:0] e);
        rd(ADDR_SPEED, {16'h0000, e}, 32'h0000_ffff);
        cmp({16'h0000, spd}, {16'h0000, e});
    endtask

    task automatic w8(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Stops released, then a clean rising switch-on edge
    task automatic power_on();
        wr(ADDR_CMD, RUN_W & 16'hfffe);
        wr(ADDR_CMD, RUN_W);
    endtask

    function automatic logic flag(input int k);
        case (k)
            0: return quick;
            1: return rstop;
            default: return fack;
        endcase
    endfunction

    // Bounded wait for a status output, then one compare
    task automatic wait_flag(input int k);
        int n;
        n = 0;
        while (flag(k) !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        cmp({31'h0000_0000, flag(k)}, 32'h0000_0001);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        err_total++;
        end_sim();
    end

    initial begin
        void'($urandom(32'h0000_8def));
        sp = 16'($urandom_range(40, 8));
        nsp = 16'h0000 - sp;
        w8(8);
        rst_i <= 1'b0;
        st(16'h0040, 16'h0044);
        rd(8'h14, 32'h0000_0000, 32'hffff_ffff);
        wr(ADDR_STATE, 16'hffff);
        st(16'h0040, 16'h0044);
        $display("done: reset and map");
        power_on();
        st(16'h0014, 16'h005c);
        wr(ADDR_SETP, sp);
        w8(60);
        spd_is(sp);
        wr(ADDR_CMD, RUN_W & 16'hf7ff);
        w8(100);
        spd_is(nsp);
        wr(ADDR_CMD, RUN_W & 16'hffdf);
        w8(60);
        spd_is(nsp);
        wr(ADDR_CMD, RUN_W & 16'hffef);
        spd_is(16'h0000);
        wr(ADDR_CMD, RUN_W);
        w8(60);
        wr(ADDR_CMD, RUN_W & 16'hffbf);
        w8(60);
        spd_is(16'h0000);
        wr(ADDR_CMD, RUN_W | 16'h1300);
        st(16'h0014, 16'h005c);
        cmp({31'h0000_0000, command_data_set_select}, 32'h0000_0000);
        wr(ADDR_CMD, RUN_W & 16'hfbf7);
        st(16'h0014, 16'h025c);
        wr(ADDR_CMD, RUN_W & 16'hfff7);
        st(16'h0200, 16'h0244);
        cmp({31'h0000_0000, pen}, 32'h0000_0000);
        wr(ADDR_CMD, RUN_W & 16'hfffd);
        st(16'h0040, 16'h0054);
        cmp({31'h0000_0000, coast}, 32'h0000_0001);
        $display("done: switch-on and ramp");
        power_on();
        w8(60);
        wr(ADDR_CMD, RUN_W & 16'hfffb);
        wait_flag(0);
        w8(30);
        st(16'h0040, 16'h0044);
        spd_is(16'h0000);
        power_on();
        w8(60);
        wr(ADDR_CMD, RUN_W & 16'hfffe);
        wait_flag(1);
        w8(60);
        st(16'h0000, 16'h0044);
        spd_is(16'h0000);
        $display("done: stops");
        power_on();
        fault_i <= 1'b1;
        w8(2);
        st(16'h0008, 16'h000c);
        fault_i <= 1'b0;
        wr(ADDR_CMD, RUN_W | 16'h0080);
        wait_flag(2);
        st(16'h0040, 16'h004c);
        wr(ADDR_CMD, RUN_W);
        st(16'h0040, 16'h0044);
        power_on();
        st(16'h0014, 16'h005c);
        $display("done: fault and lockout");
        wr(ADDR_CMD, RUN_W | 16'h2000);
        w8(40);
        wr(ADDR_CMD, RUN_W);
        rd(ADDR_SPEED, 32'h0000_0000, 32'h0000_0000);
        pot_v = rd_v[31:16];
        cmp({31'h0000_0000, pot_v > 0 && pot_v <= 24}, 32'h0000_0001);
        wr(ADDR_CMD, RUN_W | 16'h4000);
        w8(100);
        wr(ADDR_CMD, RUN_W);
        rd(ADDR_SPEED, 32'h0000_0000, 32'h0000_0000);
        pot_v = rd_v[31:16];
        cmp({31'h0000_0000, pot_v < 0}, 32'h0000_0001);
        $display("done: potentiometer");
        wr(ADDR_TEL, 16'h0014);
        wr(ADDR_CMD, RUN_W | 16'h8000);
        st(16'h8000, 16'h8000);
        cmp({31'h0000_0000, command_data_set_select}, 32'h0000_0001);
        wr(ADDR_CMD, RUN_W & 16'hf7ff);
        w8(100);
        spd_is(nsp);
        wr(ADDR_TEL, 16'h03e7);
        wr(ADDR_SETP, 16'h0001);
        w8(60);
        spd_is(nsp);
        cmp({31'h0000_0000, command_data_set_select}, 32'h0000_0000);
        $display("done: telegrams");
        end_sim();
    end
endmodule
